// ===== eod_pkg.sv
// eod_pkg: constants for the encoder pulse output and limit settings block
// assumes a 32-bit apb register window, one aligned word per register
package eod_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] EOD_ADDR_ENC = 8'h00;
  localparam logic [7:0] EOD_ADDR_TLIM = 8'h04;
  localparam logic [7:0] EOD_ADDR_OFS = 8'h08;
  localparam logic [7:0] EOD_ADDR_CTRL = 8'h0c;
  localparam logic [7:0] EOD_ADDR_STAT = 8'h10;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int EOD_ENC_W = 16;
  localparam int EOD_TL_W = 8;
  localparam int EOD_OFS_W = 11;
  localparam int EOD_SPD_W = 12;
  localparam logic [15:0] EOD_ENC_RST = 16'h0fa0;
  localparam logic [15:0] EOD_ENC_MIN = 16'h0001;
  localparam logic [7:0] EOD_TLIM_RST = 8'h64;
  localparam logic [7:0] EOD_TLIM_MAX = 8'h64;
  localparam logic [10:0] EOD_OFS_MAX = 11'h3e7;
  localparam logic [10:0] EOD_OFS_MIN = 11'h419;
  localparam logic [10:0] EOD_OFS_ZERO = 11'h000;

  // ----------------------------------------------------------------
  // control and status fields
  // ----------------------------------------------------------------
  localparam int EOD_CTRL_DIV = 0;
  localparam int EOD_CTRL_TRQ = 1;
  localparam int EOD_CTRL_AUTO = 2;
  localparam int EOD_STAT_TL_LSB = 0;
  localparam int EOD_STAT_A = 8;
  localparam int EOD_STAT_B = 9;
  localparam int EOD_STAT_LOADED = 10;

  // ----------------------------------------------------------------
  // encoder output
  // ----------------------------------------------------------------
  localparam int EOD_EDGES_PER_CYCLE = 4;
  localparam int EOD_MAX_EDGE_RATE_PPS = 1300000;
  localparam int EOD_MOTOR_RES = 10000;
  localparam logic [1:0] EOD_QUAD_STEP = 2'h1;

  typedef enum logic {EOD_DESIGNATE, EOD_DIVIDE} eod_mode_e;

endpackage : eod_pkg

// ===== eod_divider.sv
// eod_divider: emulated encoder output, torque limit and analog offsets
// assumes motor steps and analog samples come from logic on pclk
`timescale 1ns/10ps

// Overview of operation
// (R1) four programmed counts make one phase period
// (R2) software keeps edge rate within 1.3 Mpps
// (R3) designation mode: programmed edges per revolution; code gives one edge per step at most, capping it at MOTOR_RES
// (R4) division mode: resolution divided by setting
// (R5) pulse setting 1 to 65535, reset 4000
// (R6) torque limit 0 to 100, reset 100
// (R7) lower analog torque limit wins
// (R8) speed mode: offset added to speed command
// (R9) torque mode: offset corrects speed limit
// (R10) auto offset overwrites the offset setting
// (R11) offset reset taken from factory calibration
// (R12) a and b in quadrature, order gives direction
module eod_divider #(
  parameter int MOTOR_RES = eod_pkg::EOD_MOTOR_RES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic motor_step,
  input wire logic motor_dir,
  input wire logic [eod_pkg::EOD_OFS_W-1:0] analog_speed_command,
  input wire logic [eod_pkg::EOD_OFS_W-1:0] analog_speed_limit,
  input wire logic [eod_pkg::EOD_TL_W-1:0] analog_torque_limit,
  input wire logic [eod_pkg::EOD_OFS_W-1:0] measured_offset,
  input wire logic [eod_pkg::EOD_OFS_W-1:0] factory_offset,
  output logic enc_a,
  output logic enc_b,
  output logic [eod_pkg::EOD_SPD_W-1:0] corrected_speed,
  output logic [eod_pkg::EOD_TL_W-1:0] torque_limit
);
  import eod_pkg::*;

  localparam logic [31:0] RES = 32'(MOTOR_RES);

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic [EOD_ENC_W-1:0] encoder_output_pulse_setting_reg;
  logic [EOD_TL_W-1:0] internal_torque_limit_one_reg;
  logic [EOD_OFS_W-1:0] analog_speed_offset_reg;
  logic div_mode_reg;
  logic torque_mode_reg;
  logic loaded_reg;
  logic access;
  logic wr_en;
  logic bad_wr;
  logic unmapped;
  logic [31:0] rd_next;
  logic [EOD_OFS_W-1:0] wofs;

  // access phase answers after one wait cycle; pready is a flop
  assign access = psel && penable && !pready;
  assign wr_en = psel && penable && pready && pwrite && !pslverr;
  assign wofs = pwdata[EOD_OFS_W-1:0];

  always_comb begin
    unmapped = 1'b0;
    bad_wr = 1'b0;
    if (paddr == EOD_ADDR_ENC) begin
      bad_wr = pwrite && (pwdata[EOD_ENC_W-1:0] < EOD_ENC_MIN); // [R5]
    end else if (paddr == EOD_ADDR_TLIM) begin
      bad_wr = pwrite && (pwdata[EOD_TL_W-1:0] > EOD_TLIM_MAX); // [R6]
    end else if (paddr == EOD_ADDR_OFS) begin
      bad_wr = pwrite && ($signed(wofs) > $signed(EOD_OFS_MAX) ||
        $signed(wofs) < $signed(EOD_OFS_MIN));
    end else if (paddr == EOD_ADDR_CTRL) begin
      bad_wr = 1'b0;
    end else if (paddr == EOD_ADDR_STAT) begin
      bad_wr = pwrite;
    end else begin
      unmapped = 1'b1;
    end
  end

  always_comb begin
    rd_next = 32'h0;
    if (paddr == EOD_ADDR_ENC) begin
      rd_next[EOD_ENC_W-1:0] = encoder_output_pulse_setting_reg;
    end else if (paddr == EOD_ADDR_TLIM) begin
      rd_next[EOD_TL_W-1:0] = internal_torque_limit_one_reg;
    end else if (paddr == EOD_ADDR_OFS) begin
      rd_next[EOD_OFS_W-1:0] = analog_speed_offset_reg;
    end else if (paddr == EOD_ADDR_CTRL) begin
      rd_next[EOD_CTRL_DIV] = div_mode_reg;
      rd_next[EOD_CTRL_TRQ] = torque_mode_reg;
    end else if (paddr == EOD_ADDR_STAT) begin
      rd_next[EOD_STAT_TL_LSB +: EOD_TL_W] = torque_limit;
      rd_next[EOD_STAT_A] = enc_a;
      rd_next[EOD_STAT_B] = enc_b;
      rd_next[EOD_STAT_LOADED] = loaded_reg;
    end else begin
      rd_next = 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= access;
      pslverr <= access && (unmapped || bad_wr);
      if (access && !pwrite) begin
        prdata <= rd_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // settings registers
  // ----------------------------------------------------------------
  logic auto_go;
  assign auto_go = wr_en && (paddr == EOD_ADDR_CTRL) &&
    pwdata[EOD_CTRL_AUTO];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      encoder_output_pulse_setting_reg <= EOD_ENC_RST; // [R5]
      internal_torque_limit_one_reg <= EOD_TLIM_RST; // [R6]
      div_mode_reg <= EOD_DESIGNATE; // [R3]
      torque_mode_reg <= 1'b0;
    end else if (wr_en) begin
      if (paddr == EOD_ADDR_ENC) begin
        encoder_output_pulse_setting_reg <= pwdata[EOD_ENC_W-1:0];
      end else if (paddr == EOD_ADDR_TLIM) begin
        internal_torque_limit_one_reg <= pwdata[EOD_TL_W-1:0];
      end else if (paddr == EOD_ADDR_CTRL) begin
        div_mode_reg <= pwdata[EOD_CTRL_DIV];
        torque_mode_reg <= pwdata[EOD_CTRL_TRQ];
      end
    end
  end

  // a calibration value cannot be a reset constant, so the first clock
  // after release copies the factory strap into the offset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_speed_offset_reg <= EOD_OFS_ZERO;
      loaded_reg <= 1'b0;
    end else if (!loaded_reg) begin
      analog_speed_offset_reg <= factory_offset; // [R11]
      loaded_reg <= 1'b1;
    end else if (auto_go) begin
      // measurement is taken ahead of a plain offset write, though the two never share an access
      analog_speed_offset_reg <= measured_offset; // [R10]
    end else if (wr_en && paddr == EOD_ADDR_OFS) begin
      analog_speed_offset_reg <= wofs;
    end
  end

  // ----------------------------------------------------------------
  // analog corrections and torque limit
  // ----------------------------------------------------------------
  logic [EOD_SPD_W-1:0] spd_src;
  logic [EOD_SPD_W-1:0] ofs_ext;
  assign ofs_ext = {analog_speed_offset_reg[EOD_OFS_W-1],
    analog_speed_offset_reg};
  always_comb begin
    if (torque_mode_reg) begin
      spd_src = {analog_speed_limit[EOD_OFS_W-1], analog_speed_limit}; // [R9]
    end else begin
      spd_src = {analog_speed_command[EOD_OFS_W-1],
        analog_speed_command}; // [R8]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      corrected_speed <= '0;
      torque_limit <= '0;
    end else begin
      corrected_speed <= spd_src + ofs_ext; // [R8] [R9]
      // a zero setting gives zero here, so no torque at all
      if (analog_torque_limit < internal_torque_limit_one_reg) begin
        torque_limit <= analog_torque_limit; // [R7]
      end else begin
        torque_limit <= internal_torque_limit_one_reg; // [R6] [R7]
      end
    end
  end

  // ----------------------------------------------------------------
  // encoder pulse generation
  // ----------------------------------------------------------------
  // every emitted edge moves the quadrature phase a quarter period, so
  // the per-phase pulse count is a quarter of the edges; the edge rate
  // limit is left to software since no pacing is done here
  logic [31:0] acc_reg;
  logic [31:0] acc_sum;
  logic [EOD_ENC_W-1:0] div_cnt_reg;
  logic edge_now;
  logic [1:0] quad_reg;

  assign acc_sum = acc_reg + 32'(encoder_output_pulse_setting_reg);

  always_comb begin
    edge_now = 1'b0;
    if (motor_step) begin
      if (div_mode_reg == EOD_DIVIDE) begin
        edge_now = (div_cnt_reg >= encoder_output_pulse_setting_reg -
          EOD_ENC_MIN); // [R4]
      end else begin
        edge_now = (acc_sum >= RES); // [R3]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= 32'h0;
      div_cnt_reg <= '0;
    end else if (motor_step) begin
      if (div_mode_reg == EOD_DIVIDE) begin
        div_cnt_reg <= edge_now ? '0 : div_cnt_reg + EOD_ENC_MIN; // [R4]
      end else begin
        acc_reg <= edge_now ? acc_sum - RES : acc_sum; // [R3]
      end
    end
  end

  // gray walk a,b = 00,10,11,01 forward and reversed backward
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quad_reg <= 2'h0;
    end else if (edge_now) begin
      if (motor_dir) begin
        quad_reg <= quad_reg - EOD_QUAD_STEP; // [R12]
      end else begin
        quad_reg <= quad_reg + EOD_QUAD_STEP; // [R1] [R12]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enc_a <= 1'b0;
      enc_b <= 1'b0;
    end else begin
      enc_a <= quad_reg[1] ^ quad_reg[0];
      enc_b <= quad_reg[1];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_edge;
    edge_now && !motor_dir;
  endsequence

  sequence s_flip_one;
    ($changed(enc_a) && $stable(enc_b)) || ($changed(enc_b) && $stable(enc_a));
  endsequence

  a_quad_one_change: assert property (@(posedge pclk) disable iff (!presetn)
    s_edge |-> ##2 s_flip_one) // [R12]
    else $error("quadrature edge not one phase change");

  a_quad_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !edge_now |=> ##1 ($stable(enc_a) && $stable(enc_b))) // [R1]
    else $error("encoder phases moved without an edge");

  a_quad_fwd: assert property (@(posedge pclk) disable iff (!presetn)
    (edge_now && !motor_dir && quad_reg == 2'h0) |-> ##2 (enc_a && !enc_b))
    else $error("forward order wrong"); // [R12]

  // checked at the pins, so a lost edge in the quad path also shows
  a_desig_edge: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
    (motor_step && !div_mode_reg && acc_sum >= RES) |->
      ##2 ($changed(enc_a) || $changed(enc_b)))
    else $error("designation edge missing");

  a_desig_acc: assert property (@(posedge pclk) disable iff (!presetn)
    (motor_step && !div_mode_reg) |=> acc_reg < RES)
    else $error("accumulator overran resolution"); // [R3]

  a_div_period: assert property (@(posedge pclk) disable iff (!presetn)
    (motor_step && div_mode_reg && edge_now) |=> div_cnt_reg == '0)
    else $error("division counter not restarted"); // [R4]

  a_enc_range: assert property (@(posedge pclk) disable iff (!presetn)
    encoder_output_pulse_setting_reg >= EOD_ENC_MIN)
    else $error("pulse setting below one"); // [R5]

  a_tl_range: assert property (@(posedge pclk) disable iff (!presetn)
    internal_torque_limit_one_reg <= EOD_TLIM_MAX)
    else $error("torque limit above hundred"); // [R6]

  a_tl_min: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> torque_limit <= $past(internal_torque_limit_one_reg) &&
      torque_limit <= $past(analog_torque_limit))
    else $error("torque limit not the smaller"); // [R7]

  a_speed_ofs: assert property (@(posedge pclk) disable iff (!presetn)
    !torque_mode_reg |=> corrected_speed ==
      $past(spd_src) + $past(ofs_ext))
    else $error("speed command offset wrong"); // [R8]

  a_limit_ofs: assert property (@(posedge pclk) disable iff (!presetn)
    torque_mode_reg |=> corrected_speed == EOD_SPD_W'($past(
      {analog_speed_limit[EOD_OFS_W-1], analog_speed_limit}) +
      $past(ofs_ext)))
    else $error("speed limit offset wrong"); // [R9]

  a_auto_ofs: assert property (@(posedge pclk) disable iff (!presetn)
    (auto_go && loaded_reg) |=>
      analog_speed_offset_reg == $past(measured_offset))
    else $error("auto offset not stored"); // [R10]

  a_factory_ofs: assert property (@(posedge pclk) disable iff (!presetn)
    !loaded_reg |=> loaded_reg &&
      analog_speed_offset_reg == $past(factory_offset))
    else $error("factory offset not loaded"); // [R11]

  a_div_edge: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
    (motor_step && div_mode_reg &&
      div_cnt_reg >= encoder_output_pulse_setting_reg - EOD_ENC_MIN) |->
      ##2 ($changed(enc_a) || $changed(enc_b)))
    else $error("division edge missing");

  a_enc_keep: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    (psel && penable && pready && pslverr && paddr == EOD_ADDR_ENC) |=>
      $stable(encoder_output_pulse_setting_reg))
    else $error("refused pulse setting stored");

  a_tl_keep: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
    (psel && penable && pready && pslverr && paddr == EOD_ADDR_TLIM) |=>
      $stable(internal_torque_limit_one_reg))
    else $error("refused torque limit stored");

  a_tl_zero: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
    (internal_torque_limit_one_reg == '0) |=> torque_limit == '0)
    else $error("zero limit still lets torque through");

  // one wait state: the answer never stands for two cycles
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held longer than one cycle");

endmodule : eod_divider

// ===== eod_pos_counter.sv
// eod_pos_counter: far-side positioning controller counting a/b edges
// assumes enc_a/enc_b settle on pclk and start at 00 after reset
`timescale 1ns/10ps

module eod_pos_counter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enc_a,
  input wire logic enc_b,
  output int pos_count,
  output int edge_count,
  output int a_rises,
  output int bad_steps
);
  logic [1:0] prev_ab;

  // forward order 00,10,11,01; a jump of two is a lost edge
  function automatic int gidx(input logic [1:0] ab);
    return (ab == 2'b00) ? 0 : (ab == 2'b10) ? 1 : (ab == 2'b11) ? 2 : 3;
  endfunction : gidx

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_ab <= 2'b00;
      pos_count <= 0;
      edge_count <= 0;
      a_rises <= 0;
      bad_steps <= 0;
    end else if ({enc_a, enc_b} != prev_ab) begin
      prev_ab <= {enc_a, enc_b};
      edge_count <= edge_count + 1;
      case ((gidx({enc_a, enc_b}) - gidx(prev_ab) + 4) % 4)
        1: pos_count <= pos_count + 1;
        3: pos_count <= pos_count - 1;
        default: bad_steps <= bad_steps + 1;
      endcase
      if (enc_a && !prev_ab[1]) a_rises <= a_rises + 1;
    end
  end
endmodule : eod_pos_counter

// ===== encoder_pulse_output_divider_tb.sv
// encoder_pulse_output_divider_tb: self-checking bench over apb
// assumes eod_pkg constants and a one-wait-state apb slave
`timescale 1ns/10ps

module encoder_pulse_output_divider_tb;
  import eod_pkg::*;
  localparam int RES = 100;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, motor_step = 0, motor_dir = 0, enc_a, enc_b;
  logic [10:0] analog_speed_command = 0, analog_speed_limit = 0;
  logic [10:0] measured_offset = 0, factory_offset;
  logic [7:0] analog_torque_limit = 0, torque_limit;
  logic [11:0] corrected_speed;
  int pos_count, edge_count, a_rises, bad_steps;
  int miscompares = 0, checks_done = 0, seed = 32'hdd6ca652;
  int fo, ofs, tlim, mo;

  always #2.5 pclk = ~pclk;

  eod_divider #(.MOTOR_RES(RES)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .motor_step(motor_step), .motor_dir(motor_dir),
    .analog_speed_command(analog_speed_command),
    .analog_speed_limit(analog_speed_limit),
    .analog_torque_limit(analog_torque_limit),
    .measured_offset(measured_offset), .factory_offset(factory_offset),
    .enc_a(enc_a), .enc_b(enc_b), .corrected_speed(corrected_speed),
    .torque_limit(torque_limit));

  eod_pos_counter ctl (.pclk(pclk), .presetn(presetn), .enc_a(enc_a),
    .enc_b(enc_b), .pos_count(pos_count), .edge_count(edge_count),
    .a_rises(a_rises), .bad_steps(bad_steps));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // holds the request until pready is sampled high, then releases
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic e, input string nm);
    logic [31:0] rd;
    logic er;
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    // one wait state: pready is seen on the second access edge
    chk({nm, " wait"}, 32'd2, n);
    chk({nm, " err"}, {31'h0, e}, {31'h0, er});
    if (!w) chk(nm, d, rd);
  endtask : xfer

  // step gap keeps the edge rate below the output ceiling for the settings 40 and 8 used here
  task automatic steps(input int n, input logic dir);
    repeat (n) begin
      @(posedge pclk);
      motor_step <= 1;
      motor_dir <= dir;
      @(posedge pclk);
      motor_step <= 0;
      repeat (98) @(posedge pclk);
    end
    repeat (5) @(posedge pclk);
  endtask : steps

  task automatic analog(input logic trq);
    int c, l, ta, e, m;
    c = $random(seed) % 1000;
    l = $random(seed) % 1000;
    ta = {$random(seed)} % 128;
    analog_speed_command <= c[10:0];
    analog_speed_limit <= l[10:0];
    analog_torque_limit <= ta[7:0];
    repeat (3) @(posedge pclk);
    e = (trq ? l : c) + ofs;
    m = (ta < tlim) ? ta : tlim;
    chk("speed", {20'h0, e[11:0]}, {20'h0, corrected_speed});
    chk("torque_limit", m, {24'h0, torque_limit});
  endtask : analog

  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    fo = $random(seed) % 1000;
    factory_offset = fo[10:0];
    repeat (6) @(posedge pclk);
    presetn <= 1;
    xfer(0, EOD_ADDR_ENC, {16'h0, EOD_ENC_RST}, 0, "enc rst");
    xfer(0, EOD_ADDR_TLIM, {24'h0, EOD_TLIM_RST}, 0, "tlim rst");
    xfer(0, EOD_ADDR_OFS, {21'h0, fo[10:0]}, 0, "ofs rst");
    xfer(0, EOD_ADDR_STAT, 32'h400, 0, "stat rst");
    xfer(1, EOD_ADDR_ENC, 32'h0, 1, "enc zero");
    xfer(1, EOD_ADDR_TLIM, 32'h65, 1, "tlim 101");
    xfer(1, EOD_ADDR_OFS, 32'h3e8, 1, "ofs 1000");
    xfer(1, EOD_ADDR_OFS, 32'h418, 1, "ofs -1000");
    xfer(1, EOD_ADDR_STAT, 32'h0, 1, "stat wr");
    xfer(0, 8'h14, 32'h0, 1, "unmapped");
    xfer(1, EOD_ADDR_ENC, 32'hffff, 0, "enc max");
    xfer(0, EOD_ADDR_ENC, 32'hffff, 0, "enc max rd");
    xfer(1, EOD_ADDR_ENC, 32'd40, 0, "enc 40");
    steps(RES, 0);
    chk("pos fwd", 40, pos_count);
    chk("a rises", 10, a_rises);
    steps(RES, 1);
    chk("pos rev", 0, pos_count);
    chk("edges", 80, edge_count);
    xfer(1, EOD_ADDR_CTRL, 32'h1, 0, "div mode");
    xfer(1, EOD_ADDR_ENC, 32'd8, 0, "enc 8");
    steps(80, 0);
    chk("pos div", 10, pos_count);
    chk("bad steps", 0, bad_steps);
    for (int i = 0; i < 8; i++) begin
      tlim = (i == 0) ? 0 : {$random(seed)} % 101;
      ofs = $random(seed) % 1000;
      xfer(1, EOD_ADDR_TLIM, tlim, 0, "tlim");
      xfer(1, EOD_ADDR_OFS, {21'h0, ofs[10:0]}, 0, "ofs");
      xfer(1, EOD_ADDR_CTRL, {30'h0, i[0], 1'b0}, 0, "mode");
      analog(i[0]);
    end
    mo = $random(seed) % 1000;
    measured_offset <= mo[10:0];
    xfer(1, EOD_ADDR_CTRL, 32'h4, 0, "auto ofs");
    xfer(0, EOD_ADDR_OFS, {21'h0, mo[10:0]}, 0, "ofs auto");
    xfer(0, EOD_ADDR_CTRL, 32'h0, 0, "ctrl rd");
    end_of_test();
  end

  // the whole run needs about 28000 cycles
  initial begin
    repeat (60000) @(posedge pclk);
    miscompares++;
    end_of_test();
  end
endmodule : encoder_pulse_output_divider_tb
